// *** perf_error_counters.sv ***
// four e1 performance error counters with interval snapshot and mask register
// assumes framer events and bit tick are on clk_sys_in; rail pins are async
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
module perf_error_counters
    import perf_count_pkg::*;
#(
    parameter int SECOND_CYCLES = ONE_SECOND_CYCLES,
    parameter int FAST_CYCLES = FAST_INTERVAL_CYCLES
)
(
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [7:0] reg_rdata_out,
    input wire logic rx_pos_in,
    input wire logic rx_neg_in,
    input wire logic rx_bit_tick_in,
    input wire frame_event_type frame_event_in,
    input wire sync_state_type sync_state_in,
    input wire logic [7:0] irq_sources_in,
    output logic interval_timer_event_out,
    output logic int_request_out
);
    // ------------------------------------------------------------------------
    // registers and wires
    // ------------------------------------------------------------------------
    logic [1:0] pos_sync_q;
    logic [1:0] neg_sync_q;
    logic violation;
    logic [31:0] timer_q;
    logic [31:0] period;
    logic boundary;
    logic [VIOLATION_WIDTH-1:0] vio_run_q;
    logic [CRC_WIDTH-1:0] crc_run_q;
    logic [EBIT_WIDTH-1:0] ebit_run_q;
    logic [FAS_WIDTH-1:0] fas_run_q;
    logic [VIOLATION_WIDTH-1:0] vio_hold_q;
    logic [CRC_WIDTH-1:0] crc_hold_q;
    logic [EBIT_WIDTH-1:0] ebit_hold_q;
    logic [FAS_WIDTH-1:0] fas_hold_q;
    logic [7:0] mask_q;
    count_control_type ctrl_q;
    logic [7:0] rdata_d;
    logic crc_enable;
    logic ebit_event;
    logic vio_full;

    // ------------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            pos_sync_q <= 2'h0;
            neg_sync_q <= 2'h0;
        end
        else
        begin
            pos_sync_q <= {pos_sync_q[0], rx_pos_in};
            neg_sync_q <= {neg_sync_q[0], rx_neg_in};
        end
    end

    line_violation_detect u_detect (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .bit_tick_in(rx_bit_tick_in),
        .pos_in(pos_sync_q[1]),
        .neg_in(neg_sync_q[1]),
        .count_code_violations_in(ctrl_q.count_code_violations),
        .hdb3_enable_in(ctrl_q.hdb3_enable),
        .violation_out(violation)
    );

    // ------------------------------------------------------------------------
    // interval timer
    // ------------------------------------------------------------------------
    // switching the interval select mid-interval restarts nothing; the
    // running count simply meets the new period or wraps at the next boundary
    assign period = ctrl_q.interval_fast ? 32'(FAST_CYCLES)
                                         : 32'(SECOND_CYCLES); // RULE_01
    assign boundary = (timer_q >= period - 32'h1); // RULE_03

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            timer_q <= 32'h0;
        end
        else if (boundary)
        begin
            timer_q <= 32'h0;
        end
        else
        begin
            timer_q <= timer_q + 32'h1;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            interval_timer_event_out <= 1'b0;
        end
        else
        begin
            interval_timer_event_out <= boundary; // RULE_03
        end
    end

    // ------------------------------------------------------------------------
    // running counters
    // ------------------------------------------------------------------------
    assign vio_full = &vio_run_q;
    assign crc_enable = !sync_state_in.frame_sync_lost
        && !sync_state_in.crc_mf_sync_lost; // RULE_12
    assign ebit_event = frame_event_in.ebit_seen && !frame_event_in.ebit_value; // RULE_14

    // an event in the boundary cycle opens the new interval, so it is
    // neither lost nor counted twice
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            vio_run_q <= '0;
        end
        else if (boundary)
        begin
            vio_run_q <= VIOLATION_WIDTH'(violation); // RULE_22
        end
        else if (violation && !vio_full)
        begin
            vio_run_q <= vio_run_q + VIOLATION_WIDTH'(1); // RULE_09 RULE_10
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            crc_run_q <= '0;
        end
        else if (boundary)
        begin
            crc_run_q <= CRC_WIDTH'(crc_enable && frame_event_in.crc_error); // RULE_22
        end
        else if (crc_enable && frame_event_in.crc_error)
        begin
            crc_run_q <= crc_run_q + CRC_WIDTH'(1); // RULE_13
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ebit_run_q <= '0;
        end
        else if (boundary)
        begin
            ebit_run_q <= EBIT_WIDTH'(crc_enable && ebit_event); // RULE_22
        end
        else if (crc_enable && ebit_event)
        begin
            ebit_run_q <= ebit_run_q + EBIT_WIDTH'(1); // RULE_12 RULE_14
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            fas_run_q <= '0;
        end
        else if (boundary)
        begin
            fas_run_q <= FAS_WIDTH'(!sync_state_in.frame_sync_lost
                && frame_event_in.fas_error); // RULE_22
        end
        else if (!sync_state_in.frame_sync_lost && frame_event_in.fas_error)
        begin
            fas_run_q <= fas_run_q + FAS_WIDTH'(1); // RULE_16 RULE_17
        end
    end

    // ------------------------------------------------------------------------
    // readable snapshots
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            vio_hold_q <= '0;
            crc_hold_q <= '0;
            ebit_hold_q <= '0;
            fas_hold_q <= '0;
        end
        else if (boundary)
        begin
            vio_hold_q <= vio_run_q; // RULE_01 RULE_02
            crc_hold_q <= crc_run_q; // RULE_01 RULE_02
            ebit_hold_q <= ebit_run_q; // RULE_01 RULE_02
            fas_hold_q <= fas_run_q; // RULE_01 RULE_02
        end
    end

    // ------------------------------------------------------------------------
    // register port
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            mask_q <= INTERRUPT_MASK_RESET;
            ctrl_q <= COUNT_CONTROL_RESET;
        end
        else if (reg_write_in)
        begin
            if (reg_addr_in == INTERRUPT_MASK_TWO_ADDR)
            begin
                mask_q <= reg_wdata_in;
            end
            if (reg_addr_in == COUNT_CONTROL_ADDR)
            begin
                ctrl_q.interval_fast <= reg_wdata_in[CTRL_INTERVAL_BIT];
                ctrl_q.count_code_violations <= reg_wdata_in[CTRL_VIOLATION_TYPE_BIT];
                ctrl_q.hdb3_enable <= reg_wdata_in[CTRL_HDB3_BIT];
            end
        end
    end

    always_comb
    begin
        rdata_d = UNMAPPED_READ;
        unique case (reg_addr_in)
            VIOLATION_COUNT_HIGH_ADDR: rdata_d = vio_hold_q[15:8]; // RULE_04
            VIOLATION_COUNT_LOW_ADDR: rdata_d = vio_hold_q[7:0]; // RULE_04
            CRC_FAS_HIGH_ADDR: rdata_d = {fas_hold_q[11:6], crc_hold_q[9:8]}; // RULE_11 RULE_18 RULE_19
            CRC_COUNT_LOW_ADDR: rdata_d = crc_hold_q[7:0]; // RULE_11
            EBIT_FAS_LOW_ADDR: rdata_d = {fas_hold_q[5:0], ebit_hold_q[9:8]}; // RULE_15 RULE_18 RULE_19
            EBIT_COUNT_LOW_ADDR: rdata_d = ebit_hold_q[7:0]; // RULE_15
            INTERRUPT_MASK_TWO_ADDR: rdata_d = mask_q;
            COUNT_CONTROL_ADDR: rdata_d = {5'h00, ctrl_q};
            default: rdata_d = UNMAPPED_READ;
        endcase
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            reg_rdata_out <= 8'h00;
        end
        else if (reg_read_in)
        begin
            reg_rdata_out <= rdata_d;
        end
        else
        begin
            reg_rdata_out <= 8'h00;
        end
    end

    // ------------------------------------------------------------------------
    // interrupt gating
    // ------------------------------------------------------------------------
    // bit 4 is fed by this block's own timer; the other sources come from outside
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            int_request_out <= 1'b0;
        end
        else
        begin
            int_request_out <= |(mask_q & {irq_sources_in[7:5],
                interval_timer_event_out, irq_sources_in[3:0]}); // RULE_20 RULE_21
        end
    end

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    logic [31:0] since_boundary_q;

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            since_boundary_q <= 32'h0;
        end
        else if (boundary)
        begin
            since_boundary_q <= 32'h0;
        end
        else
        begin
            since_boundary_q <= since_boundary_q + 32'h1;
        end
    end

    a_snapshot_copy: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RULE_01
        boundary |=> (vio_hold_q == $past(vio_run_q)) && (fas_hold_q == $past(fas_run_q)))
        else $error("snapshot does not match running count");

    a_hold_stable: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RULE_02
        !boundary |=> $stable(vio_hold_q) && $stable(crc_hold_q) && $stable(ebit_hold_q))
        else $error("readable count changed inside an interval");

    // a late switch to the short period may leave the count past it for the boundary cycle
    a_interval_length: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RULE_03
        (since_boundary_q < period) || boundary)
        else $error("interval ran past its period");

    a_vio_saturate: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RULE_10
        (vio_full && !boundary) |=> vio_full)
        else $error("violation counter wrapped");

    a_vio_counts: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RULE_09
        (violation && !vio_full && !boundary) |=> vio_run_q == $past(vio_run_q) + 16'h1)
        else $error("violation not counted");

    a_crc_held: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RULE_12
        (sync_state_in.crc_mf_sync_lost && !boundary) |=> $stable(crc_run_q) && $stable(ebit_run_q))
        else $error("crc4 or e-bit counted during sync loss");

    a_fas_held: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RULE_17
        (sync_state_in.frame_sync_lost && !boundary) |=> $stable(fas_run_q))
        else $error("fas counted during frame sync loss");

    a_restart_zero: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RULE_22
        (boundary && !violation) |=> vio_run_q == 16'h0)
        else $error("counter not restarted at boundary");

    a_shared_byte: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RULE_18
        (reg_read_in && reg_addr_in == CRC_FAS_HIGH_ADDR)
        |=> reg_rdata_out == {fas_hold_q[11:6], crc_hold_q[9:8]})
        else $error("shared byte layout wrong");

    a_mask_gate: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RULE_20
        (mask_q == 8'h00) |=> !int_request_out)
        else $error("masked source raised interrupt");

    c_boundary: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in) boundary);
    c_saturated: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in) vio_full);
    c_interrupt: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in) int_request_out);
endmodule

// *** perf_count_pkg.sv ***
// constants, field layouts and carrier types for the e1 error counter block
// assumes one 20 MHz system clock and a byte-wide register port
// ----------------------------------------------------------------------------
// How it works
// RULE_01: snapshot counts each second, or each 62.5 ms
// RULE_02: readable copies hold previous interval, stay stable
// RULE_03: boundaries come from the interval timer event
// RULE_04: 16-bit violation count at 0x00 and 0x01
// RULE_05: select 0 counts bipolar violations
// RULE_06: skip hdb3 substitution violations when decoding hdb3
// RULE_07: select 1 counts code violations
// RULE_08: software picks mode to suit line code
// RULE_09: violation counter counts in every sync state
// RULE_10: violation counter saturates at 65535
// RULE_11: 10-bit crc4 count at 0x02[1:0] and 0x03
// RULE_12: crc4/e-bit held on fas or crc4 loss
// RULE_13: crc4/e-bit counters need no saturation
// RULE_14: count each received e bit equal zero
// RULE_15: 10-bit e-bit count at 0x04[1:0] and 0x05
// RULE_16: 12-bit counter of fas word errors
// RULE_17: fas counter held only on frame sync loss
// RULE_18: fas bits 11:6 at 0x02, 5:0 at 0x04
// RULE_19: shared bytes carry crc4 and e-bit tops
// RULE_20: mask bit 0 masks, 1 enables source
// RULE_21: mask bits gate the eight listed sources
// RULE_22: copy and restart in one cycle
// ----------------------------------------------------------------------------
package perf_count_pkg;

    // ------------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------------
    localparam logic [7:0] VIOLATION_COUNT_HIGH_ADDR = 8'h00;
    localparam logic [7:0] VIOLATION_COUNT_LOW_ADDR = 8'h01;
    localparam logic [7:0] CRC_FAS_HIGH_ADDR = 8'h02;
    localparam logic [7:0] CRC_COUNT_LOW_ADDR = 8'h03;
    localparam logic [7:0] EBIT_FAS_LOW_ADDR = 8'h04;
    localparam logic [7:0] EBIT_COUNT_LOW_ADDR = 8'h05;
    localparam logic [7:0] INTERRUPT_MASK_TWO_ADDR = 8'h17;
    localparam logic [7:0] COUNT_CONTROL_ADDR = 8'h1a;

    // ------------------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------------------
    localparam int VIOLATION_WIDTH = 16;
    localparam int CRC_WIDTH = 10;
    localparam int EBIT_WIDTH = 10;
    localparam int FAS_WIDTH = 12;
    localparam int SHARED_TOP_LSB = 2;
    localparam int CTRL_INTERVAL_BIT = 2;
    localparam int CTRL_VIOLATION_TYPE_BIT = 1;
    localparam int CTRL_HDB3_BIT = 0;
    localparam int MASK_TIMER_BIT = 4;
    localparam logic [7:0] INTERRUPT_MASK_RESET = 8'h00;
    localparam logic [2:0] COUNT_CONTROL_RESET = 3'h0;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ------------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int ONE_SECOND_NS = 1000000000;
    localparam int FAST_INTERVAL_NS = 62500000;
    localparam int ONE_SECOND_CYCLES = ONE_SECOND_NS / CLK_PERIOD_NS;
    localparam int FAST_INTERVAL_CYCLES = FAST_INTERVAL_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic frame_sync_lost;
        logic crc_mf_sync_lost;
        logic cas_mf_sync_lost;
    } sync_state_type;

    typedef struct packed {
        logic crc_error;
        logic ebit_seen;
        logic ebit_value;
        logic fas_error;
    } frame_event_type;

    typedef struct packed {
        logic interval_fast;
        logic count_code_violations;
        logic hdb3_enable;
    } count_control_type;

endpackage

// *** line_violation_detect.sv ***
// detects bipolar and code violations on the received dual-rail line
// assumes rail inputs are already in the system clock domain
`timescale 1ns/1ps
module line_violation_detect
    import perf_count_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic bit_tick_in,
    input wire logic pos_in,
    input wire logic neg_in,
    input wire logic count_code_violations_in,
    input wire logic hdb3_enable_in,
    output logic violation_out
);
    logic last_mark_neg_q;
    logic last_v_neg_q;
    logic [2:0] zero_hist_q;
    logic last_was_v_q;
    logic seen_mark_q;
    logic mark;
    logic mark_neg;
    logic bpv;
    logic substitution;
    logic code_violation;
    logic violation_d;

    assign mark = pos_in ^ neg_in;
    assign mark_neg = neg_in;
    // two marks of one polarity in a row
    // the first mark after reset has no earlier mark to clash with
    assign bpv = mark && seen_mark_q && (mark_neg == last_mark_neg_q); // RULE_05
    // 000v or b00v: two zeros before v, and before that a zero or a plain mark
    assign substitution = zero_hist_q[0] && zero_hist_q[1]
        && (zero_hist_q[2] || !last_was_v_q); // RULE_06
    // consecutive violations of the same polarity
    assign code_violation = bpv && (mark_neg == last_v_neg_q); // RULE_07

    always_comb
    begin
        if (count_code_violations_in)
        begin
            violation_d = bit_tick_in && code_violation; // RULE_07
        end
        else
        begin
            violation_d = bit_tick_in && bpv
                && !(hdb3_enable_in && substitution); // RULE_06
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            last_mark_neg_q <= 1'b0;
            last_v_neg_q <= 1'b0;
            zero_hist_q <= 3'h0;
            last_was_v_q <= 1'b0;
            seen_mark_q <= 1'b0;
        end
        else if (bit_tick_in)
        begin
            zero_hist_q <= {zero_hist_q[1:0], !mark};
            if (mark)
            begin
                last_mark_neg_q <= mark_neg;
                last_was_v_q <= bpv;
                seen_mark_q <= 1'b1;
            end
            if (bpv)
            begin
                last_v_neg_q <= mark_neg;
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            violation_out <= 1'b0;
        end
        else
        begin
            violation_out <= violation_d;
        end
    end
endmodule

// *** e1_line_model.sv ***
// dual-rail e1 receive line model feeding the error counter block
// assumes the block syncs the rails and samples them on the bit tick
`timescale 1ns/1ps
module e1_line_model
(
    input wire logic clk_sys_in,
    output logic rx_pos_out,
    output logic rx_neg_out,
    output logic bit_tick_out
);
    initial
    begin
        rx_pos_out = 1'b0;
        rx_neg_out = 1'b0;
        bit_tick_out = 1'b0;
    end

    // ------------------------------------------------------------------------
    // one symbol per char: P mark, N mark, 0 space
    // ------------------------------------------------------------------------
    // rails settle two cycles before the tick to cover the two-stage sync
    task automatic send(input string s);
        for (int i = 0; i < s.len(); i++)
        begin
            @(posedge clk_sys_in);
            rx_pos_out <= (s[i] == "P");
            rx_neg_out <= (s[i] == "N");
            repeat (2) @(posedge clk_sys_in);
            bit_tick_out <= 1'b1;
            @(posedge clk_sys_in);
            bit_tick_out <= 1'b0;
            rx_pos_out <= 1'b0;
            rx_neg_out <= 1'b0;
        end
    endtask
endmodule

// *** perf_error_counters_tb_top.sv ***
// self-checking bench for the e1 performance error counters
// assumes short interval parameters so several boundaries fit in one run
`timescale 1ns/1ps
module perf_error_counters_tb_top;
    import perf_count_pkg::*;
    localparam int SEC_CYC = 200;
    localparam int FAST_CYC = 50;
    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] irq_src = 8'h00;
    logic [7:0] reg_rdata;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic rx_pos, rx_neg, tick, tmr_evt, int_req;
    frame_event_type fev = '0;
    sync_state_type sst = '0;
    int error_cnt = 0;
    int checks_done = 0;
    int n;

    always #25 clk_sys_in = ~clk_sys_in;

    perf_error_counters #(.SECOND_CYCLES(SEC_CYC), .FAST_CYCLES(FAST_CYC)) DUT (
        .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr),
        .reg_wdata_in(reg_wdata), .reg_write_in(reg_write), .reg_read_in(reg_read),
        .reg_rdata_out(reg_rdata), .rx_pos_in(rx_pos), .rx_neg_in(rx_neg),
        .rx_bit_tick_in(tick), .frame_event_in(fev), .sync_state_in(sst),
        .irq_sources_in(irq_src), .interval_timer_event_out(tmr_evt),
        .int_request_out(int_req));

    e1_line_model LM (.clk_sys_in(clk_sys_in), .rx_pos_out(rx_pos), .rx_neg_out(rx_neg),
        .bit_tick_out(tick));

    // ------------------------------------------------------------------------
    // access and compare tasks
    // ------------------------------------------------------------------------
    task automatic tally_and_finish();
        if (error_cnt == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
            error_cnt++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys_in);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge clk_sys_in);
        reg_write <= 1'b0;
    endtask

    // data stand only in the cycle after the strobe edge
    task automatic rchk(input string name, input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys_in);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk_sys_in);
        reg_read <= 1'b0;
        #1;
        chk(name, exp, reg_rdata);
    endtask

    task automatic wait_pulse(output int cyc);
        cyc = 0;
        do
        begin
            @(posedge clk_sys_in);
            #1;
            cyc++;
        end
        while (tmr_evt !== 1'b1 && cyc < 1000);
        if (tmr_evt !== 1'b1)
        begin
            $display("[FAIL] interval pulse expected 1 seen %b", tmr_evt);
            error_cnt++;
            tally_and_finish();
        end
    endtask

    task automatic ev(input frame_event_type e, input sync_state_type s);
        @(posedge clk_sys_in);
        fev <= e;
        sst <= s;
        @(posedge clk_sys_in);
        fev <= '0;
    endtask

    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial
    begin
        repeat (8) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        for (int a = 0; a < 6; a++)
            rchk("count reset", 8'(a), 8'h00);
        rchk("mask reset", 8'h17, INTERRUPT_MASK_RESET);
        wr(8'h01, 8'hff);
        rchk("count read only", 8'h01, 8'h00);
        wr(8'h30, 8'hff);
        rchk("unmapped", 8'h30, UNMAPPED_READ);
        // each mask bit except timer bit 4 gates only its own source
        for (int b = 0; b < 8; b++)
        begin
            if (b != MASK_TIMER_BIT)
            begin
                wr(8'h17, 8'h01 << b);
                rchk("mask readback", 8'h17, 8'h01 << b);
                @(posedge clk_sys_in) irq_src <= 8'h01 << b;
                @(posedge clk_sys_in);
                #1 chk("irq enabled", 8'h01, {7'h0, int_req});
                @(posedge clk_sys_in) irq_src <= ~(8'h01 << b);
                @(posedge clk_sys_in);
                #1 chk("irq masked", 8'h00, {7'h0, int_req});
            end
        end
        @(posedge clk_sys_in) irq_src <= 8'h00;
        wr(8'h17, 8'h10);
        wait_pulse(n);
        @(posedge clk_sys_in);
        #1 chk("timer irq", 8'h01, {7'h0, int_req});
        wr(8'h17, 8'h00);
        wait_pulse(n);
        wait_pulse(n);
        chk("second period", 8'(SEC_CYC), 8'(n));
        // blocked and counted events in one interval
        for (int i = 0; i < 77; i++)
        begin
            if (i < 70)
                ev({i < 4, i < 5, i >= 3, 1'b1}, 3'b000);
            else if (i < 73)
                ev(4'b1101, 3'b100);
            else if (i < 75)
                ev(4'b1101, 3'b010);
            else
                ev(4'b1101, 3'b001);
        end
        sst <= '0;
        wait_pulse(n);
        rchk("crc fas high", 8'h02, 8'h04);
        rchk("crc low", 8'h03, 8'h06);
        rchk("ebit fas low", 8'h04, 8'h28);
        rchk("ebit low", 8'h05, 8'h05);
        repeat (100) @(posedge clk_sys_in);
        rchk("held copy", 8'h03, 8'h06);
        wait_pulse(n);
        rchk("restarted", 8'h03, 8'h00);
        // bipolar counting without and with hdb3 decoding
        for (int h = 0; h < 2; h++)
        begin
            wait_pulse(n);
            wr(8'h1a, 8'(h));
            LM.send("PPN000N");
            wait_pulse(n);
            rchk("violation high", 8'h00, 8'h00);
            rchk("bipolar count", 8'h01, 8'(2 - h));
        end
        // code violations, with every sync state lost
        wait_pulse(n);
        @(posedge clk_sys_in) sst <= '1;
        wr(8'h1a, 8'h02);
        LM.send("PPN");
        wait_pulse(n);
        LM.send("PPNPPN");
        wait_pulse(n);
        rchk("code violations", 8'h01, 8'h02);
        @(posedge clk_sys_in) sst <= '0;
        // changing the select mid-interval makes the next period irregular
        wr(8'h1a, 8'h04);
        wait_pulse(n);
        wait_pulse(n);
        chk("fast period", 8'(FAST_CYC), 8'(n));
        tally_and_finish();
    end
endmodule
